// ---- logic/dpm_pkg.sv ----
// Purpose: Shared constants and types for the dock power-role and mux control block.
// Assumes: One 100 MHz clock; all pin inputs synchronous to it.
// Notes: Pin indices select one of the eight general-purpose pins.

// =====================================================================
// Package
// =====================================================================
package dpm_pkg;

   localparam int DPM_GPIO_NUM = 8;
   localparam int DPM_EVT_NUM = 7;
   localparam int DPM_PIN_W = 3;
   localparam int DPM_PDO_W = 3;

   // Event positions in the output event vector.
   localparam int DPM_EVT_ALT = 0;
   localparam int DPM_EVT_MUX_EN = 1;
   localparam int DPM_EVT_POL = 2;
   localparam int DPM_EVT_PLUG = 3;
   localparam int DPM_EVT_V9 = 4;
   localparam int DPM_EVT_V15 = 5;
   localparam int DPM_EVT_V20 = 6;

   // Power object numbers of the negotiated contract.
   localparam logic [DPM_PDO_W-1:0] DPM_PDO_5V = 3'h1;
   localparam logic [DPM_PDO_W-1:0] DPM_PDO_9V = 3'h2;
   localparam logic [DPM_PDO_W-1:0] DPM_PDO_15V = 3'h3;
   localparam logic [DPM_PDO_W-1:0] DPM_PDO_20V = 3'h4;

   // Source objects offered while the external supply is present: 5, 9, 15, 20 V.
   localparam logic [3:0] DPM_SRC_PDO_ALL = 4'h000f;
   localparam logic [3:0] DPM_SRC_PDO_NONE = 4'h0000;

   // Reset values.
   localparam logic [1:0] DPM_RST_SYNC_INIT = 2'h0;
   localparam logic [DPM_GPIO_NUM-1:0] DPM_GPIO_RST = 8'h00;
   localparam logic [7:0] DPM_BYTE_RST = 8'h00;

   typedef enum logic [3:0]
   {
      DPM_ST_IDLE = 4'h0001,
      DPM_ST_SINK = 4'h0002,
      DPM_ST_SWAP = 4'h0004,
      DPM_ST_SOURCE = 4'h0008
   } dpm_state_e;

   typedef struct packed
   {
      logic polarity;
      logic enable;
      logic alt_sel;
   } dpm_mux_s;

   typedef struct packed
   {
      logic v20;
      logic v15;
      logic v9;
   } dpm_volt_s;

   typedef logic [DPM_EVT_NUM-1:0][DPM_PIN_W-1:0] dpm_pin_map_t;

endpackage : dpm_pkg

// ---- logic/dpm_core.sv ----
// Purpose: Power role, contract voltage select and SuperSpeed mux control for a dock port.
// Assumes: A PD engine outside this block reports attach, contracts and swap completion.
// Notes: All control bits are plain ports; there is no register bus.
//
// Notes on behaviour
// (RULE_01) Supply present first: try source role.
// (RULE_02) Source attaches first: boot VBUS, power flash.
// (RULE_03) Supply appears as sink: offer PDOs, swap.
// (RULE_04) Orientation from CC sets mux lane mode.
// (RULE_05) Support pin assignments C and D.
// (RULE_06) Drive alternate-mode select to the mux.
// (RULE_07) Enable mux only while it is needed.
// (RULE_08) Polarity output follows cable orientation.
// (RULE_09) Any mux event maps to any pin.
// (RULE_10) Sample supply detect on chosen input pin.
// (RULE_11) With supply: no sink request, offer 5-20 V.
// (RULE_12) Supply lost: leave source contract, renegotiate sink.
// (RULE_13) Supply back: resend source caps, renegotiate.
// (RULE_14) Plug event output high on every attach.
// (RULE_15) One output marks 9, 15, 20 V contract.
// (RULE_16) Interrupt the system controller on state change.
// (RULE_17) Controller writes image; device stores it.
// (RULE_18) One voltage output; clear on detach, 5 V.

`timescale 1ns/100ps

module dpm_core
   import dpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [DPM_GPIO_NUM-1:0] gpio_in,
   input wire logic [DPM_PIN_W-1:0] jack_pin_sel,
   input wire dpm_pin_map_t evt_pin_sel,
   input wire logic cc1_detect,
   input wire logic cc2_detect,
   input wire logic dp_cfg_valid,
   input wire logic dp_pin_assign_c,
   input wire logic contract_valid,
   input wire logic [DPM_PDO_W-1:0] contract_pdo,
   input wire logic swap_done,
   input wire logic sink_path_allow,
   input wire logic fw_wr_valid,
   input wire logic [7:0] fw_wr_data,
   input wire logic irq_clear,
   output logic [DPM_GPIO_NUM-1:0] gpio_out,
   output logic [DPM_GPIO_NUM-1:0] gpio_oe,
   output logic req_source_role,
   output logic vbus_boot,
   output logic flash_power_en,
   output logic external_fet_path,
   output logic sink_request_en,
   output logic [3:0] source_pdo_mask,
   output logic send_pr_swap,
   output logic send_source_caps,
   output logic renegotiate_sink,
   output logic flash_wr_valid,
   output logic [7:0] flash_wr_data,
   output logic irq_n
);

   // ==================================================================
   // Reset synchroniser
   // ==================================================================
   logic [1:0] rst_sync_r;
   logic rst_n_i;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= DPM_RST_SYNC_INIT;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end

   assign rst_n_i = rst_sync_r[1];

   // ==================================================================
   // Input sampling
   // ==================================================================
   logic jack_r, jack_nxt;
   logic attached;

   // The detect level comes from whichever pin is configured as its input.
   always_comb
   begin
      jack_nxt = gpio_in[jack_pin_sel]; // RULE_10
   end

   always_ff @(posedge clk or negedge rst_n_i)
   begin
      if (!rst_n_i)
         jack_r <= 1'b0;
      else
         jack_r <= jack_nxt;
   end

   assign attached = cc1_detect | cc2_detect;

   // ==================================================================
   // Power role state machine
   // ==================================================================
   dpm_state_e st_r, st_nxt;
   logic src_req_r, src_req_nxt;
   logic swap_r, swap_nxt;
   logic caps_r, caps_nxt;
   logic reneg_r, reneg_nxt;
   logic boot_r, boot_nxt;
   logic snk_req_r, snk_req_nxt;
   logic ext_r, ext_nxt;
   logic [3:0] pdo_r, pdo_nxt;

   always_comb
   begin
      st_nxt = st_r;
      src_req_nxt = 1'b0;
      swap_nxt = 1'b0;
      caps_nxt = 1'b0;
      reneg_nxt = 1'b0;
      boot_nxt = boot_r;
      unique case (st_r)
         DPM_ST_IDLE:
         begin
            if (attached && jack_r)
            begin
               st_nxt = DPM_ST_SOURCE; // RULE_01
               src_req_nxt = 1'b1; // RULE_01
            end
            else if (attached)
            begin
               st_nxt = DPM_ST_SINK; // RULE_02
               boot_nxt = 1'b1; // RULE_02
            end
         end
         DPM_ST_SINK:
         begin
            if (jack_r)
            begin
               st_nxt = DPM_ST_SWAP; // RULE_03
               swap_nxt = 1'b1; // RULE_03
            end
         end
         DPM_ST_SWAP:
         begin
            if (!jack_r)
               st_nxt = DPM_ST_SINK;
            else if (swap_done)
            begin
               st_nxt = DPM_ST_SOURCE;
               caps_nxt = 1'b1; // RULE_13
            end
         end
         DPM_ST_SOURCE:
         begin
            if (!jack_r)
            begin
               st_nxt = DPM_ST_SINK; // RULE_12
               reneg_nxt = 1'b1; // RULE_12
            end
         end
      endcase
      // Detach wins over every transition so no stale request leaves the block.
      if (!attached)
      begin
         st_nxt = DPM_ST_IDLE;
         src_req_nxt = 1'b0;
         swap_nxt = 1'b0;
         caps_nxt = 1'b0;
         reneg_nxt = 1'b0;
         boot_nxt = 1'b0;
      end
      snk_req_nxt = (st_nxt == DPM_ST_SINK) && !jack_r; // RULE_11
      ext_nxt = (st_nxt == DPM_ST_SINK) && sink_path_allow; // RULE_02
      if ((st_nxt == DPM_ST_SOURCE) || (st_nxt == DPM_ST_SWAP))
         pdo_nxt = DPM_SRC_PDO_ALL; // RULE_11
      else
         pdo_nxt = DPM_SRC_PDO_NONE;
   end

   always_ff @(posedge clk or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r <= DPM_ST_IDLE;
         src_req_r <= 1'b0;
         swap_r <= 1'b0;
         caps_r <= 1'b0;
         reneg_r <= 1'b0;
         boot_r <= 1'b0;
         snk_req_r <= 1'b0;
         ext_r <= 1'b0;
         pdo_r <= DPM_SRC_PDO_NONE;
      end
      else
      begin
         st_r <= st_nxt;
         src_req_r <= src_req_nxt;
         swap_r <= swap_nxt;
         caps_r <= caps_nxt;
         reneg_r <= reneg_nxt;
         boot_r <= boot_nxt;
         snk_req_r <= snk_req_nxt;
         ext_r <= ext_nxt;
         pdo_r <= pdo_nxt;
      end
   end

   // ==================================================================
   // Contract voltage, plug event and mux control
   // ==================================================================
   dpm_volt_s volt_r, volt_nxt;
   dpm_mux_s mux_r, mux_nxt;
   logic cfg_r, cfg_nxt;
   logic plug_r, plug_nxt;

   always_comb
   begin
      volt_nxt = volt_r;
      if (!attached || (st_nxt != DPM_ST_SOURCE))
         volt_nxt = '0; // RULE_18
      else if (contract_valid)
      begin
         // Exactly one bit or none, so the feedback network never sees two taps.
         volt_nxt.v9 = (contract_pdo == DPM_PDO_9V); // RULE_15
         volt_nxt.v15 = (contract_pdo == DPM_PDO_15V); // RULE_15
         volt_nxt.v20 = (contract_pdo == DPM_PDO_20V); // RULE_15
      end
      plug_nxt = attached; // RULE_14
      cfg_nxt = cfg_r;
      mux_nxt = mux_r;
      if (!attached)
      begin
         cfg_nxt = 1'b0;
         mux_nxt.alt_sel = 1'b0;
         mux_nxt.polarity = 1'b0;
      end
      else
      begin
         mux_nxt.polarity = cc2_detect; // RULE_04 RULE_08
         if (dp_cfg_valid)
         begin
            cfg_nxt = 1'b1;
            mux_nxt.alt_sel = dp_pin_assign_c; // RULE_05 RULE_06
         end
      end
      mux_nxt.enable = attached && cfg_nxt; // RULE_07
   end

   always_ff @(posedge clk or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         volt_r <= '0;
         mux_r <= '0;
         cfg_r <= 1'b0;
         plug_r <= 1'b0;
      end
      else
      begin
         volt_r <= volt_nxt;
         mux_r <= mux_nxt;
         cfg_r <= cfg_nxt;
         plug_r <= plug_nxt;
      end
   end

   // ==================================================================
   // Event to pin mapping
   // ==================================================================
   logic [DPM_EVT_NUM-1:0] evt;
   logic [DPM_GPIO_NUM-1:0] gpio_r, gpio_nxt;
   logic [DPM_GPIO_NUM-1:0] oe_r, oe_nxt;

   assign evt = {volt_r.v20, volt_r.v15, volt_r.v9, plug_r,
                 mux_r.polarity, mux_r.enable, mux_r.alt_sel};

   // Two events mapped to one pin are OR-ed; the detect pin is never driven.
   for (genvar p = 0; p < DPM_GPIO_NUM; p++)
   begin : g_pin
      always_comb
      begin
         gpio_nxt[p] = 1'b0;
         oe_nxt[p] = 1'b0;
         for (int e = 0; e < DPM_EVT_NUM; e++)
         begin
            if (evt_pin_sel[e] == DPM_PIN_W'(p))
            begin
               gpio_nxt[p] = gpio_nxt[p] | evt[e]; // RULE_09
               oe_nxt[p] = 1'b1; // RULE_09
            end
         end
         if (jack_pin_sel == DPM_PIN_W'(p))
         begin
            gpio_nxt[p] = 1'b0;
            oe_nxt[p] = 1'b0;
         end
      end

      always_ff @(posedge clk or negedge rst_n_i)
      begin
         if (!rst_n_i)
         begin
            gpio_r[p] <= 1'b0;
            oe_r[p] <= 1'b0;
         end
         else
         begin
            gpio_r[p] <= gpio_nxt[p];
            oe_r[p] <= oe_nxt[p];
         end
      end
   end

   // ==================================================================
   // Interrupt and firmware path
   // ==================================================================
   logic [DPM_EVT_NUM+4:0] stat, stat_q_r;
   logic irq_r, irq_nxt;
   logic fwv_r, fwv_nxt;
   logic [7:0] fwd_r, fwd_nxt;

   assign stat = {st_r, evt, jack_r};

   always_comb
   begin
      // A change in the clear cycle still raises the line: set wins.
      irq_nxt = (stat != stat_q_r) | (irq_r & ~irq_clear); // RULE_16
      fwv_nxt = fw_wr_valid; // RULE_17
      fwd_nxt = fw_wr_valid ? fw_wr_data : fwd_r; // RULE_17
   end

   always_ff @(posedge clk or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stat_q_r <= {DPM_ST_IDLE, {(DPM_EVT_NUM + 1){1'b0}}};
         irq_r <= 1'b0;
         fwv_r <= 1'b0;
         fwd_r <= DPM_BYTE_RST;
      end
      else
      begin
         stat_q_r <= stat;
         irq_r <= irq_nxt;
         fwv_r <= fwv_nxt;
         fwd_r <= fwd_nxt;
      end
   end

   // ==================================================================
   // Outputs
   // ==================================================================
   assign gpio_out = gpio_r;
   assign gpio_oe = oe_r;
   assign req_source_role = src_req_r;
   assign vbus_boot = boot_r;
   assign flash_power_en = boot_r;
   assign external_fet_path = ext_r;
   assign sink_request_en = snk_req_r;
   assign source_pdo_mask = pdo_r;
   assign send_pr_swap = swap_r;
   assign send_source_caps = caps_r;
   assign renegotiate_sink = reneg_r;
   assign flash_wr_valid = fwv_r;
   assign flash_wr_data = fwd_r;
   assign irq_n = ~irq_r;

   // ==================================================================
   // Assertions
   // ==================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_i);

   AST_SRC_FIRST: assert property ((st_r == DPM_ST_IDLE) && attached && jack_r |=> // RULE_01
      req_source_role && (st_r == DPM_ST_SOURCE)) else $error("source attempt missing");
   AST_BOOT: assert property ((st_r == DPM_ST_IDLE) && attached && !jack_r |=> // RULE_02
      vbus_boot && flash_power_en) else $error("no VBUS boot");
   AST_SWAP: assert property ((st_r == DPM_ST_SINK) && attached && jack_r |=> // RULE_03
      send_pr_swap && (source_pdo_mask == DPM_SRC_PDO_ALL)) else $error("swap missing");
   AST_POL: assert property (attached |=> mux_r.polarity == $past(cc2_detect)) // RULE_08
      else $error("polarity wrong");
   AST_ALT: assert property (attached && dp_cfg_valid |=> // RULE_06
      mux_r.alt_sel == $past(dp_pin_assign_c) && mux_r.enable) else $error("alt select wrong");
   AST_MUX_OFF: assert property (!attached |=> !mux_r.enable) // RULE_07
      else $error("mux enabled while detached");
   AST_NO_SINK_REQ: assert property (jack_r && $past(jack_r) |-> !sink_request_en) // RULE_11
      else $error("sink request with supply");
   AST_LOSS: assert property ((st_r == DPM_ST_SOURCE) && attached && !jack_r |=> // RULE_12
      renegotiate_sink && (volt_r == '0)) else $error("no exit on supply loss");
   AST_CAPS: assert property ((st_r == DPM_ST_SWAP) && attached && jack_r && swap_done |=> // RULE_13
      send_source_caps ##1 !send_source_caps) else $error("caps not sent");
   AST_PLUG: assert property ($rose(attached) |=> plug_r ##1 // RULE_14
      evt[DPM_EVT_PLUG] == $past(attached)) else $error("plug event missing");
   AST_V20: assert property ((st_nxt == DPM_ST_SOURCE) && attached && contract_valid // RULE_15
      && (contract_pdo == DPM_PDO_20V) |=> volt_r.v20) else $error("20 V flag missing");
   AST_ONEHOT: assert property ($onehot0(volt_r)) else $error("two voltage flags"); // RULE_18
   AST_V5: assert property (attached && contract_valid && (contract_pdo == DPM_PDO_5V) // RULE_18
      |=> volt_r == '0) else $error("flags not cleared at 5 V");
   AST_IRQ: assert property ((stat != stat_q_r) |=> !irq_n) // RULE_16
      else $error("interrupt missing");
   AST_FW: assert property (fw_wr_valid |=> // RULE_17
      flash_wr_valid && flash_wr_data == $past(fw_wr_data)) else $error("image byte lost");

   COV_SRC: cover property ((st_r == DPM_ST_IDLE) ##1 (st_r == DPM_ST_SOURCE));
   COV_SWAP: cover property (send_pr_swap ##[1:50] send_source_caps);
   COV_LOSS: cover property (renegotiate_sink);
   COV_V15: cover property (volt_r.v15);

endmodule : dpm_core

// ---- testbench/dpm_partner.sv ----
// Purpose: Port partner model across the cable for the dock block bench.
// Assumes: Bench commands to the partner are one-cycle pulses on clk.
// Notes: Replies come ans_dly cycles late, so the partner can be prompt or slow.

`timescale 1ns/100ps

// =====================================================================
// Port partner
// =====================================================================
module dpm_partner
   import dpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic attach,
   input wire logic flip,
   input wire logic [3:0] ans_dly,
   input wire logic [DPM_PDO_W-1:0] want_pdo,
   input wire logic req_contract,
   input wire logic send_pr_swap,
   input wire logic send_source_caps,
   output logic cc1_detect,
   output logic cc2_detect,
   output logic swap_done,
   output logic contract_valid,
   output logic [DPM_PDO_W-1:0] contract_pdo
);
   logic [3:0] cnt_r;
   logic is_swap_r;

   assign cc1_detect = attach & ~flip;
   assign cc2_detect = attach & flip;

   // An idle object number toggles every cycle, so a design that reads it late is caught.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 4'h0;
         is_swap_r <= 1'b0;
         swap_done <= 1'b0;
         contract_valid <= 1'b0;
         contract_pdo <= 3'h0;
      end
      else
      begin
         swap_done <= (cnt_r == 4'h1) & is_swap_r;
         contract_valid <= req_contract | ((cnt_r == 4'h1) & ~is_swap_r);
         contract_pdo <= (req_contract | (cnt_r == 4'h1)) ? want_pdo : ~contract_pdo;
         if (send_pr_swap | send_source_caps)
         begin
            cnt_r <= ans_dly;
            is_swap_r <= send_pr_swap;
         end
         else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule : dpm_partner

// ---- testbench/dpm_core_tb_top.sv ----
// Purpose: Self-checking bench for the dock power-role and mux control block.
// Assumes: The partner model stands on the cable side; the bench drives pins.
// Notes: Two rounds, each with its own random pin map; the second flips orientation and slows the partner.

`timescale 1ns/100ps

// =====================================================================
// Bench top
// =====================================================================
module dpm_core_tb_top
   import dpm_pkg::*;
;
   logic clk, rst_n = 1'b0, attach = 1'b0, flip = 1'b0, req_contract = 1'b0;
   logic dp_cfg_valid = 1'b0, dp_pin_assign_c = 1'b0, sink_path_allow = 1'b0;
   logic fw_wr_valid = 1'b0, irq_clear = 1'b0, alt0, cc1, cc2, swap_done, contract_valid;
   logic req_source_role, vbus_boot, flash_power_en, external_fet_path, sink_request_en;
   logic send_pr_swap, send_source_caps, renegotiate_sink, flash_wr_valid, irq_n;
   logic [7:0] gpio_in = 8'h00, fw_wr_data = 8'h00, gpio_out, gpio_oe, flash_wr_data, obs;
   logic [3:0] ans_dly = 4'h1, source_pdo_mask;
   logic [2:0] jb = 3'h0, want_pdo = 3'h1, p, contract_pdo;
   logic [31:0] seed = 32'h0000_002f;
   dpm_pin_map_t evt_pin_sel = '0;
   int err_count = 0, comparisons = 0;

   assign obs = {~irq_n, external_fet_path, flash_wr_valid, vbus_boot, renegotiate_sink,
      send_source_caps, send_pr_swap, req_source_role};

   dpm_core DUT
   (
      .clk(clk), .rst_n(rst_n), .gpio_in(gpio_in), .jack_pin_sel(jb),
      .evt_pin_sel(evt_pin_sel), .cc1_detect(cc1), .cc2_detect(cc2),
      .dp_cfg_valid(dp_cfg_valid), .dp_pin_assign_c(dp_pin_assign_c),
      .contract_valid(contract_valid), .contract_pdo(contract_pdo), .swap_done(swap_done),
      .sink_path_allow(sink_path_allow), .fw_wr_valid(fw_wr_valid), .fw_wr_data(fw_wr_data),
      .irq_clear(irq_clear), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .req_source_role(req_source_role), .vbus_boot(vbus_boot),
      .flash_power_en(flash_power_en), .external_fet_path(external_fet_path),
      .sink_request_en(sink_request_en), .source_pdo_mask(source_pdo_mask),
      .send_pr_swap(send_pr_swap), .send_source_caps(send_source_caps),
      .renegotiate_sink(renegotiate_sink), .flash_wr_valid(flash_wr_valid),
      .flash_wr_data(flash_wr_data), .irq_n(irq_n)
   );

   dpm_partner partner
   (
      .clk(clk), .rst_n(rst_n), .attach(attach), .flip(flip), .ans_dly(ans_dly),
      .want_pdo(want_pdo), .req_contract(req_contract), .send_pr_swap(send_pr_swap),
      .send_source_caps(send_source_caps), .cc1_detect(cc1), .cc2_detect(cc2),
      .swap_done(swap_done), .contract_valid(contract_valid), .contract_pdo(contract_pdo)
   );

   // =====================================================================
   // Helpers
   // =====================================================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   function automatic logic ev(input int e);
      return gpio_out[3'(jb + 3'(e + 1))];
   endfunction : ev

   function automatic logic [7:0] volts();
      return {5'h0, ev(DPM_EVT_V20), ev(DPM_EVT_V15), ev(DPM_EVT_V9)};
   endfunction : volts

   function automatic logic [7:0] vexp(input logic [2:0] q);
      return (q == DPM_PDO_9V) ? 8'h01 : (q == DPM_PDO_15V) ? 8'h02 :
         (q == DPM_PDO_20V) ? 8'h04 : 8'h00;
   endfunction : vexp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wait_obs(input int i, input string what);
      int n;
      n = 0;
      @(negedge clk);
      while (obs[i] !== 1'b1 && n < 12)
      begin
         @(negedge clk);
         n++;
      end
      chk({7'h0, obs[i]}, 8'h01, what);
   endtask : wait_obs

   task automatic fire(input int k, input logic [7:0] d);
      @(posedge clk);
      want_pdo <= d[2:0];
      fw_wr_data <= d;
      dp_pin_assign_c <= d[0];
      case (k)
         0: dp_cfg_valid <= 1'b1;
         1: req_contract <= 1'b1;
         2: fw_wr_valid <= 1'b1;
         default: irq_clear <= 1'b1;
      endcase
      @(posedge clk);
      dp_cfg_valid <= 1'b0;
      req_contract <= 1'b0;
      fw_wr_valid <= 1'b0;
      irq_clear <= 1'b0;
   endtask : fire

   task automatic set_jack(input logic v);
      logic [7:0] g;
      @(posedge clk);
      seed = xs(seed);
      g = seed[7:0];
      g[jb] = v;
      gpio_in <= g;
   endtask : set_jack

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // =====================================================================
   // Clock, watchdog and scenarios
   // =====================================================================
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      wrap_up();
   end

   initial
   begin
      for (int r = 0; r < 2; r++)
      begin
         seed = xs(seed);
         @(posedge clk);
         rst_n <= 1'b0;
         attach <= 1'b0;
         jb <= seed[2:0];
         flip <= r[0];
         ans_dly <= r[0] ? 4'h6 : 4'h1;
         sink_path_allow <= seed[8];
         for (int e = 0; e < DPM_EVT_NUM; e++)
            evt_pin_sel[e] <= 3'(seed[2:0] + 3'(e + 1));
         repeat (8) @(posedge clk);
         rst_n <= 1'b1;
         repeat (4) @(posedge clk);
         set_jack(1'b1);
         repeat (3) @(posedge clk);
         attach <= 1'b1;
         wait_obs(0, "source role request");
         repeat (2) @(negedge clk);
         chk({4'h0, source_pdo_mask}, 8'h0f, "source offers");
         chk({7'h0, sink_request_en}, 8'h00, "sink request");
         chk({7'h0, ev(DPM_EVT_PLUG)}, 8'h01, "plug pin");
         chk({7'h0, ev(DPM_EVT_POL)}, {7'h0, flip}, "polarity pin");
         chk(gpio_oe, ~(8'h01 << jb), "pin enables");
         for (int k = 0; k < 2; k++)
         begin
            fire(0, 8'(k));
            repeat (3) @(negedge clk);
            chk({7'h0, ev(DPM_EVT_MUX_EN)}, 8'h01, "mux enable");
            if (k == 0)
               alt0 = ev(DPM_EVT_ALT);
         end
         chk({7'h0, alt0 ^ ev(DPM_EVT_ALT)}, 8'h01, "lane mode");
         for (int i = 0; i < 5; i++)
         begin
            p = (i == 3) ? 3'h1 : ((i == 4) ? 3'h4 : 3'(i + 2));
            fire(1, {5'h0, p});
            repeat (5) @(negedge clk);
            chk(volts(), vexp(p), "voltage pins");
         end
         set_jack(1'b0);
         wait_obs(3, "sink renegotiation");
         repeat (3) @(negedge clk);
         chk(volts(), 8'h00, "voltage pins cleared");
         chk({6'h0, sink_request_en, external_fet_path}, {7'h1, sink_path_allow}, "sink");
         set_jack(1'b1);
         wait_obs(1, "role swap");
         wait_obs(2, "source capabilities");
         repeat (12) @(negedge clk);
         chk({4'h0, source_pdo_mask}, 8'h0f, "source offers again");
         chk(volts(), vexp(p), "renegotiated pins");
         for (int i = 0; i < 4; i++)
         begin
            seed = xs(seed);
            fire(2, seed[7:0]);
            @(negedge clk);
            chk({7'h0, flash_wr_valid}, 8'h01, "flash strobe");
            chk(flash_wr_data, seed[7:0], "flash byte");
         end
         fire(3, 8'h00);
         repeat (2) @(negedge clk);
         chk({7'h0, irq_n}, 8'h01, "interrupt cleared");
         @(posedge clk);
         attach <= 1'b0;
         wait_obs(7, "interrupt on detach");
         repeat (3) @(negedge clk);
         chk(volts() | {4'h0, ev(DPM_EVT_MUX_EN), 3'h0}, 8'h00, "detached pins");
         set_jack(1'b0);
         repeat (3) @(posedge clk);
         attach <= 1'b1;
         wait_obs(4, "boot from bus");
         repeat (2) @(negedge clk);
         chk({6'h0, flash_power_en, ev(DPM_EVT_PLUG)}, 8'h03, "flash power");
         @(posedge clk);
         attach <= 1'b0;
         repeat (3) @(negedge clk);
         chk({6'h0, vbus_boot, flash_power_en}, 8'h00, "boot released");
      end
      wrap_up();
   end
endmodule : dpm_core_tb_top
